/* File: common/anv_pkg.sv */
package anv_pkg;
  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 40;

  // ---------------------------------------------------------------
  // Timing in ns, and derived clock counts
  // ---------------------------------------------------------------
  localparam int CYCLE_TIME_NS = 35;
  localparam int CYCLE_TIME_EXT_NS = 45;
  localparam int HIGH_HOLD_NS = 2;
  localparam int ADDR_TO_END_NS = 20;
  localparam int ADDR_TO_END_EXT_NS = 30;
  localparam int WR_PULSE_NS = 15;
  localparam int DATA_VALID_BEFORE_END_NS = 10;
  localparam int OE_ACCESS_TIME_NS = 15;
  localparam int LANE_ACCESS_TIME_NS = 15;
  localparam int ADDR_ACCESS_NS = 35;
  localparam int ADDR_ACCESS_EXT_NS = 45;
  localparam int RELEASE_NS = 15;
  localparam int WR_RECOVER_NS = 12;
  localparam int STARTUP_NS = 2000000;

  // Least times round up, never below one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  localparam int CYCLE_TIME_CYC = ns_to_cyc(CYCLE_TIME_EXT_NS);
  localparam int WR_PULSE_CYC = ns_to_cyc(ADDR_TO_END_EXT_NS);
  localparam int DATA_SETUP_CYC = ns_to_cyc(DATA_VALID_BEFORE_END_NS);
  localparam int RD_WAIT_CYC = ns_to_cyc(ADDR_ACCESS_EXT_NS);
  localparam int HIGH_HOLD_CYC = ns_to_cyc(HIGH_HOLD_NS);
  localparam int RECOVER_CYC = ns_to_cyc(RELEASE_NS);
  localparam int STARTUP_CYC = ns_to_cyc(STARTUP_NS);

  typedef enum logic [2:0] {
    ANV_BOOT = 3'b000,
    ANV_IDLE = 3'b001,
    ANV_RD = 3'b010,
    ANV_WR = 3'b011,
    ANV_GAP = 3'b100
  } anv_state_e;
endpackage : anv_pkg

/* File: rtl/anv_timer.sv */
`timescale 1ns/1ns
// Down counter: load a count, pulse done when it reaches one
module anv_timer import anv_pkg::*; #(
  parameter int W = 17
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = value;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign busy = (cnt_q != '0);
  assign done = (cnt_q == W'(1)); // Last cycle of the wait
endmodule : anv_timer

/* File: rtl/anv_host.sv */
`timescale 1ns/1ns
module anv_host import anv_pkg::*; #(
  parameter int STARTUP_CYCLES = STARTUP_CYC,
  parameter int CNT_W = 17
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_lanes,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic [ADDR_W-1:0] mem_addr,
  output logic chip_sel_n,
  output logic wr_strobe_n,
  output logic out_en_n,
  output logic hi_lane_sel_n,
  output logic lo_lane_sel_n,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe
);
  anv_state_e st_q, st_d;
  logic ready_q, ready_d;
  logic rsp_q, rsp_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic cs_q, cs_d, we_q, we_d, oe_q, oe_d, hi_q, hi_d, lo_q, lo_d;
  logic [DATA_W-1:0] dout_q, dout_d;
  logic doe_q, doe_d;
  logic tload;
  logic [CNT_W-1:0] tval;
  logic tbusy, tdone;

  // ---------------------------------------------------------------
  // Wait timer shared by every phase
  // ---------------------------------------------------------------
  anv_timer #(.W(CNT_W)) u_timer (
    .clk(clk),
    .reset(reset),
    .load(tload),
    .value(tval),
    .busy(tbusy),
    .done(tdone)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Each write is one whole cycle of select low, each read two; gap keeps all strobes high
  always_comb begin
    st_d = st_q;
    ready_d = 1'b0;
    rsp_d = 1'b0;
    rdata_d = rdata_q;
    addr_d = addr_q;
    cs_d = cs_q;
    we_d = we_q;
    oe_d = oe_q;
    hi_d = hi_q;
    lo_d = lo_q;
    dout_d = dout_q;
    doe_d = doe_q;
    tload = 1'b0;
    tval = '0;
    case (st_q)
      ANV_BOOT: begin
        // Strobes held high through the power-up wait
        if (!tbusy) begin
          tload = 1'b1;
          tval = CNT_W'(STARTUP_CYCLES);
        end
        if (tdone) begin
          st_d = ANV_IDLE;
          ready_d = 1'b1;
        end
      end
      ANV_IDLE: begin
        ready_d = 1'b1;
        if (req_valid && ready_q && req_lanes != 2'b00) begin
          ready_d = 1'b0;
          // Address driven with select, never after it
          addr_d = req_addr;
          cs_d = 1'b0;
          // Both lanes switch on one edge, zero skew
          hi_d = ~req_lanes[1];
          lo_d = ~req_lanes[0];
          tload = 1'b1;
          if (req_write) begin
            // Strobe falls with select, output enable stays high
            we_d = 1'b0;
            dout_d = req_wdata;
            doe_d = 1'b1; // Device already floated at this edge
            tval = CNT_W'(WR_PULSE_CYC);
            st_d = ANV_WR;
          end else begin
            we_d = 1'b1;
            oe_d = 1'b0;
            tval = CNT_W'(RD_WAIT_CYC); // Covers address, enable, lane access
            st_d = ANV_RD;
          end
        end
      end
      ANV_RD: begin
        if (tdone) begin
          rdata_d = dq_in; // Sampled before any address change
          rsp_d = 1'b1;
          cs_d = 1'b1;
          oe_d = 1'b1;
          hi_d = 1'b1;
          lo_d = 1'b1;
          tload = 1'b1;
          tval = CNT_W'(RECOVER_CYC); // Bus released before next drive
          st_d = ANV_GAP;
        end
      end
      ANV_WR: begin
        // Pulse and data setup both cover the longest need
        if (tdone) begin
          // Select and strobe rise together: overlap ends here
          cs_d = 1'b1;
          we_d = 1'b1;
          hi_d = 1'b1;
          lo_d = 1'b1;
          rsp_d = 1'b1;
          tload = 1'b1;
          tval = CNT_W'(RECOVER_CYC);
          st_d = ANV_GAP;
        end
      end
      ANV_GAP: begin
        // Data held one cycle past the end edge, dropped as the gap ends
        doe_d = 1'b0;
        // Strobes stay high, spacing select falls
        if (tdone) begin
          st_d = ANV_IDLE;
          ready_d = 1'b1;
        end
      end
      default: begin
        st_d = ANV_BOOT;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= ANV_BOOT;
      ready_q <= 1'b0;
      rsp_q <= 1'b0;
      rdata_q <= '0;
      addr_q <= '0;
      cs_q <= 1'b1;
      we_q <= 1'b1;
      oe_q <= 1'b1;
      hi_q <= 1'b1;
      lo_q <= 1'b1;
      dout_q <= '0;
      doe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ready_q <= ready_d;
      rsp_q <= rsp_d;
      rdata_q <= rdata_d;
      addr_q <= addr_d;
      cs_q <= cs_d;
      we_q <= we_d;
      oe_q <= oe_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ---------------------------------------------------------------
  assign req_ready = ready_q;
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
  assign mem_addr = addr_q;
  assign chip_sel_n = cs_q;
  assign wr_strobe_n = we_q;
  assign out_en_n = oe_q;
  assign hi_lane_sel_n = hi_q;
  assign lo_lane_sel_n = lo_q;
  assign dq_out = dout_q;
  assign dq_oe = doe_q;
endmodule : anv_host

/* File: tb/anv_mem_model.sv */
`timescale 1ns/1ns
// ----
// Behavioural memory, low 8 address bits only
// ----
module anv_mem_model import anv_pkg::*; (
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic chip_sel_n,
  input wire logic wr_strobe_n,
  input wire logic out_en_n,
  input wire logic hi_lane_sel_n,
  input wire logic lo_lane_sel_n,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe,
  output logic [DATA_W-1:0] dq_in
);
  logic [DATA_W-1:0] mem [0:255];
  logic rd_lo;
  logic rd_hi;
  initial begin
    dq_in = 16'h5A5A;
    for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
  end
  // Store only inside the select and strobe overlap
  always @* begin
    if (!chip_sel_n && !wr_strobe_n && dq_oe) begin
      if (!lo_lane_sel_n) mem[mem_addr[7:0]][7:0] = dq_out[7:0];
      if (!hi_lane_sel_n) mem[mem_addr[7:0]][15:8] = dq_out[15:8];
    end
  end
  // Drive only in a real read; a floated lane inverts its last value at each address or read-enable change
  assign rd_lo = !chip_sel_n && !out_en_n && wr_strobe_n && !lo_lane_sel_n;
  assign rd_hi = !chip_sel_n && !out_en_n && wr_strobe_n && !hi_lane_sel_n;
  always @(mem_addr or rd_lo or rd_hi) begin
    dq_in[7:0] <= #10 rd_lo ? mem[mem_addr[7:0]][7:0] : ~dq_in[7:0];
    dq_in[15:8] <= #10 rd_hi ? mem[mem_addr[7:0]][15:8] : ~dq_in[15:8];
  end
endmodule : anv_mem_model

/* File: tb/anv_host_chk.sv */
`timescale 1ns/1ns
// ----
// Pin protocol checks
// ----
module anv_host_chk import anv_pkg::*; #(
  parameter int STARTUP_CYCLES = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic chip_sel_n,
  input wire logic wr_strobe_n,
  input wire logic out_en_n,
  input wire logic hi_lane_sel_n,
  input wire logic lo_lane_sel_n,
  input wire logic dq_oe
);
  // Saturating cycle count since reset
  logic [17:0] boot_q;
  logic [17:0] boot_d;
  always_comb boot_d = &boot_q ? boot_q : boot_q + 18'h00001;
  always_ff @(posedge clk) boot_q <= reset ? 18'h00000 : boot_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // One-cycle pulse: 40 ns covers both the width and the address window
  sequence s_wr_low; !wr_strobe_n && !chip_sel_n && dq_oe; endsequence
  sequence s_wr_end; wr_strobe_n && chip_sel_n; endsequence
  property p_boot; boot_q <= STARTUP_CYCLES |-> chip_sel_n && wr_strobe_n && !req_ready; endproperty
  a_boot: assert property (p_boot) else $error("strobe low in power-up wait");
  property p_rd; !out_en_n |-> wr_strobe_n && !dq_oe; endproperty
  a_rd: assert property (p_rd) else $error("strobe or drive in read");
  property p_hold; $rose(chip_sel_n) |=> chip_sel_n && wr_strobe_n; endproperty
  a_hold: assert property (p_hold) else $error("select high too short");
  property p_cyc; $fell(chip_sel_n) |=> !$fell(chip_sel_n) [*2]; endproperty
  a_cyc: assert property (p_cyc) else $error("select falls too close");
  property p_lane; $fell(hi_lane_sel_n) || $fell(lo_lane_sel_n) |-> $fell(chip_sel_n); endproperty
  a_lane: assert property (p_lane) else $error("lane select skewed");
  property p_addr; !chip_sel_n && !$fell(chip_sel_n) |-> $stable(mem_addr); endproperty
  a_addr: assert property (p_addr) else $error("address moved in access");
  property p_pulse; $fell(wr_strobe_n) |-> s_wr_low ##1 s_wr_end; endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse wrong length");
  property p_wdat; !wr_strobe_n |-> dq_oe && !chip_sel_n && out_en_n; endproperty
  a_wdat: assert property (p_wdat) else $error("write data not driven");
  property p_one; !chip_sel_n |-> !req_ready; endproperty
  a_one: assert property (p_one) else $error("ready during access");
  property p_rsp; $fell(out_en_n) |-> ##[2:4] rsp_valid; endproperty
  a_rsp: assert property (p_rsp) else $error("read answer late");
endmodule : anv_host_chk
bind anv_host anv_host_chk #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_chk (.clk, .reset, .req_ready, .rsp_valid,
  .mem_addr, .chip_sel_n, .wr_strobe_n, .out_en_n, .hi_lane_sel_n, .lo_lane_sel_n, .dq_oe);

/* File: tb/async_nv_memory_port_test.sv */
`timescale 1ns/1ns
module async_nv_memory_port_test import anv_pkg::*;;
  typedef struct packed {logic w; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d; logic [1:0] l; logic [DATA_W-1:0] e;} anv_row_s;
  logic clk = 0, reset = 1, req_valid = 0, req_write = 0, req_ready, rsp_valid, cs_n, wr_n, oe_n, hi_n, lo_n, dq_oe;
  logic [ADDR_W-1:0] req_addr = 0, mem_addr;
  logic [DATA_W-1:0] req_wdata = 0, rsp_rdata, dq_in, dq_out, got;
  logic [1:0] req_lanes = 0;
  int fail_count = 0, num_checks = 0, cycles = 0;
  // ----
  // Ordinary cases: write, lane write, top address
  // ----
  anv_row_s rows [7] = '{'{1, 21'h000010, 16'hA5C3, 2'h3, 0}, '{0, 21'h000010, 0, 2'h3, 16'hA5C3},
    '{1, 21'h000010, 16'h1234, 2'h1, 0}, '{0, 21'h000010, 0, 2'h3, 16'hA534},
    '{1, 21'h1FFFFF, 16'hBEEF, 2'h2, 0}, '{0, 21'h1FFFFF, 0, 2'h2, 16'hBE00}, '{0, 21'h1FFFFF, 0, 2'h1, 16'h0000}};
  always #20 clk = ~clk;
  anv_host #(.STARTUP_CYCLES(4)) uut (.clk, .reset, .req_valid, .req_write, .req_addr, .req_wdata, .req_lanes,
    .req_ready, .rsp_valid, .rsp_rdata, .mem_addr, .chip_sel_n(cs_n), .wr_strobe_n(wr_n), .out_en_n(oe_n),
    .hi_lane_sel_n(hi_n), .lo_lane_sel_n(lo_n), .dq_in, .dq_out, .dq_oe);
  anv_mem_model mem (.mem_addr, .chip_sel_n(cs_n), .wr_strobe_n(wr_n), .out_en_n(oe_n), .hi_lane_sel_n(hi_n),
    .lo_lane_sel_n(lo_n), .dq_out, .dq_oe, .dq_in);
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // Hang guard, a few thousand cycles is far beyond the sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      final_report();
    end
  end
  task chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] m);
    num_checks++;
    if ((g & m) !== (e & m)) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // Request held until taken, then wait for the one-cycle answer
  task access(input anv_row_s r);
    logic rdy;
    int n;
    req_valid = 1;
    {req_write, req_addr, req_wdata, req_lanes} = {r.w, r.a, r.d, r.l};
    n = 0;
    do begin
      rdy = req_ready;
      @(posedge clk);
      #1 n++;
    end while (rdy !== 1 && n < 50);
    req_valid = 0;
    while (rsp_valid !== 1 && n < 80) begin
      @(posedge clk);
      #1 n++;
    end
    got = rsp_rdata;
    chk({15'h0000, rsp_valid}, 16'h0001, 16'hFFFF);
  endtask : access
  initial begin
    repeat (8) @(posedge clk);
    #1 reset = 0;
    chk({13'h0000, cs_n, wr_n, req_ready}, 16'h0006, 16'hFFFF);
    foreach (rows[i]) begin
      access(rows[i]);
      if (!rows[i].w) chk(got, rows[i].e, {{8{rows[i].l[1]}}, {8{rows[i].l[0]}}});
    end
    // Empty lane mask must never start a cycle
    {req_valid, req_lanes} = 3'b100;
    repeat (8) begin
      @(posedge clk);
      #1 chk({15'h0000, cs_n}, 16'h0001, 16'hFFFF);
    end
    // Reset in the middle of a write
    {req_write, req_addr, req_lanes} = {1'b1, 21'h000020, 2'h3};
    repeat (20) if (cs_n !== 0) begin
      @(posedge clk);
      #1;
    end
    // Select still low here, so the reset cuts a live write
    {reset, req_valid} = 2'b10;
    repeat (8) @(posedge clk);
    #1 reset = 0;
    chk({12'h000, dq_oe, cs_n, wr_n, req_ready}, 16'h0006, 16'hFFFF);
    access('{0, 21'h000010, 0, 2'h3, 0});
    chk(got, 16'hA534, 16'hFFFF);
    final_report();
  end
endmodule : async_nv_memory_port_test
